// file: cie_alu.sv
// Arithmetic and logic unit with status flag generation.
`timescale 1ns/10ps
module cie_alu
  import cie_pkg::*;
(
  input  cie_pkg::cie_fn_t fn,
  input  logic [7:0]       a,
  input  logic [7:0]       b,
  input  logic             cin,
  input  logic [7:0]       flags_in,
  output logic [7:0]       res,
  output logic [7:0]       flags_out
);

  logic [8:0] sum9;

  always_comb begin
    sum9      = 9'h000;
    res       = b;
    flags_out = flags_in;
    case (fn)
      fn_add: begin
        sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        res  = sum9[7:0];
        flags_out[FLAG_C] = sum9[8];
        flags_out[FLAG_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
        flags_out[FLAG_V] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
      end
      fn_sub: begin
        sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        res  = sum9[7:0];
        flags_out[FLAG_C] = sum9[8];
        flags_out[FLAG_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
        flags_out[FLAG_V] = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
      end
      fn_and: begin
        res = a & b;
        flags_out[FLAG_V] = 1'b0;
      end
      fn_or: begin
        res = a | b;
        flags_out[FLAG_V] = 1'b0;
      end
      fn_xor: begin
        res = a ^ b;
        flags_out[FLAG_V] = 1'b0;
      end
      default: begin
        res = b;
      end
    endcase
    // The signed flag is kept as N xor V so signed branches reduce to one flag test.
    if (fn != fn_pass) begin
      flags_out[FLAG_Z] = (res == 8'h00);
      flags_out[FLAG_N] = res[7];
      flags_out[FLAG_S] = res[7] ^ flags_out[FLAG_V];
    end
  end

endmodule

// file: cie_core.sv
// Instruction execution core with an AHB-Lite command and register slave.
`timescale 1ns/10ps
module cie_core
  import cie_pkg::*;
#(
  parameter int STACK_DEPTH = 3
) (
  input  logic        hclk,
  input  logic        hresetn,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic [31:0] hrdata,
  output logic        hresp,
  output logic [4:0]  io_addr,
  input  logic [7:0]  io_rdata
);

  // ****************************************
  // Bus slave state
  // ****************************************
  logic          ph_act_q;
  logic          ph_wr_q;
  logic [7:0]    ph_adr_q;
  logic          bus_fin;
  logic          stall;
  logic [31:0]   rdmux;

  // ****************************************
  // Core state
  // ****************************************
  cie_state_t         st_q;
  logic [31:0]        ins_q;
  logic [CIE_PC_W-1:0] pc_q;
  logic [7:0]         flags_q;
  logic [2:0]         cnt_q;
  logic [2:0]         last_cyc_q;
  logic               taken_q;
  logic [CIE_PC_W-1:0] stk_q [STACK_DEPTH];

  // ****************************************
  // Decode
  // ****************************************
  cie_op_t             op;
  logic [4:0]          d_idx;
  logic [4:0]          r_idx;
  logic [7:0]          kc;
  logic [2:0]          bsel;
  logic [CIE_PC_W-1:0] koff;
  cie_fn_t             fn;
  logic                use_k;
  logic                use_c;
  logic                wr_rd;
  logic                wr_fl;
  logic                take;
  logic                push;
  logic                pop;
  logic [2:0]          cyc;
  logic [CIE_PC_W-1:0] pc_nx;
  logic [7:0]          rd_a;
  logic [7:0]          rd_b;
  logic [7:0]          rd_c;
  logic [7:0]          ptr;
  logic [7:0]          alu_res;
  logic [7:0]          alu_fl;
  logic                rf_we;
  logic [4:0]          rf_wa;
  logic [7:0]          rf_wd;
  logic [4:0]          ra_b;
  logic                exec;
  logic                bus_rf_wr;

  assign exec  = (st_q == st_exec);
  assign op    = cie_op_t'(ins_q[CIE_OP_LSB +: 6]);
  assign d_idx = ins_q[CIE_D_LSB +: 5];
  assign r_idx = ins_q[CIE_R_LSB +: 5];
  assign kc    = ins_q[7:0];
  assign bsel  = ins_q[CIE_R_LSB +: 3];
  assign koff  = ins_q[CIE_PC_W-1:0];

  always_comb begin
    fn    = fn_pass;
    use_k = 1'b0;
    use_c = 1'b0;
    wr_rd = 1'b0;
    wr_fl = 1'b0;
    take  = 1'b0;
    push  = 1'b0;
    pop   = 1'b0;
    cyc   = CYC_ONE;
    pc_nx = pc_q + 12'h001;
    case (op)
      op_add: begin
        fn = fn_add; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      op_add_carry: begin
        fn = fn_add; use_c = 1'b1; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      op_sub: begin
        fn = fn_sub; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      op_sub_const: begin
        fn = fn_sub; use_k = 1'b1; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      op_sub_carry: begin
        fn = fn_sub; use_c = 1'b1; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      difference_const_with_carry: begin
        fn = fn_sub; use_k = 1'b1; use_c = 1'b1; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      op_and: begin
        fn = fn_and; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      bitwise_conjunction_const: begin
        fn = fn_and; use_k = 1'b1; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      op_or: begin
        fn = fn_or; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      op_or_const: begin
        fn = fn_or; use_k = 1'b1; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      exclusive_disjunction: begin
        fn = fn_xor; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      clear_reg_bits: begin
        fn = fn_and; use_k = 1'b1; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      zero_minus_check: begin
        fn = fn_and; wr_rd = 1'b1; wr_fl = 1'b1;
      end
      op_compare: begin
        fn = fn_sub; wr_fl = 1'b1;
      end
      op_compare_carry: begin
        fn = fn_sub; use_c = 1'b1; wr_fl = 1'b1;
      end
      compare_immediate: begin
        fn = fn_sub; use_k = 1'b1; wr_fl = 1'b1;
      end
      reg_copy: begin
        wr_rd = 1'b1;
      end
      relative_jump: begin
        cyc   = CYC_JUMP;
        pc_nx = pc_q + koff + 12'h001;
      end
      relative_call: begin
        cyc   = CYC_CALL;
        push  = 1'b1;
        pc_nx = pc_q + koff + 12'h001;
      end
      subroutine_exit, handler_exit: begin
        cyc   = CYC_RET;
        pop   = 1'b1;
        pc_nx = stk_q[0];
      end
      skip_if_equal:     take = (rd_a == rd_b);
      skip_reg_bit_low:  take = ~rd_b[bsel];
      skip_reg_bit_high: take = rd_b[bsel];
      skip_io_bit_low:   take = ~io_rdata[bsel];
      skip_io_bit_high:  take = io_rdata[bsel];
      // Named branches map onto these two: signed tests use S, unsigned use C.
      branch_flag_high:  take = flags_q[bsel];
      branch_flag_low:   take = ~flags_q[bsel];
      indirect_read: begin
        wr_rd = 1'b1;
        cyc   = CYC_MEM;
      end
      indirect_write: begin
        cyc = CYC_MEM;
      end
      default: begin
        cyc = CYC_ONE;
      end
    endcase
    // The skipped instruction is assumed to be one word long.
    if (take) begin
      cyc = CYC_TAKEN;
      if (op == branch_flag_high || op == branch_flag_low) begin
        pc_nx = pc_q + koff + 12'h001;
      end else begin
        pc_nx = pc_q + 12'h002;
      end
    end
  end

  // ****************************************
  // Datapath
  // ****************************************
  assign ra_b = (op == indirect_read) ? ptr[4:0] : r_idx;

  cie_regfile #(
    .N (32)
  ) u_rf (
    .clk   (hclk),
    .rst_n (hresetn),
    .we    (rf_we),
    .waddr (rf_wa),
    .wdata (rf_wd),
    .ra_a  (d_idx),
    .ra_b  (ra_b),
    .ra_c  (ph_adr_q[6:2]),
    .rd_a  (rd_a),
    .rd_b  (rd_b),
    .rd_c  (rd_c),
    .ptr   (ptr)
  );

  cie_alu u_alu (
    .fn        (fn),
    .a         (rd_a),
    .b         (use_k ? ((op == clear_reg_bits) ? ~kc : kc) : rd_b),
    .cin       (use_c & flags_q[FLAG_C]),
    .flags_in  (flags_q),
    .res       (alu_res),
    .flags_out (alu_fl)
  );

  // Bus writes to the register window only reach the file while the core is idle.
  assign bus_rf_wr = bus_fin && ph_wr_q && ph_adr_q[7];

  always_comb begin
    rf_we = 1'b0;
    rf_wa = d_idx;
    rf_wd = alu_res;
    if (exec && op == indirect_write) begin
      rf_we = 1'b1;
      rf_wa = ptr[4:0];
      rf_wd = rd_b;
    end else if (exec && wr_rd) begin
      rf_we = 1'b1;
      rf_wd = (op == indirect_read) ? rd_b : alu_res;
    end else if (bus_rf_wr) begin
      rf_we = 1'b1;
      rf_wa = ph_adr_q[6:2];
      rf_wd = hwdata[7:0];
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= st_idle;
      cnt_q      <= 3'h0;
      last_cyc_q <= 3'h0;
      taken_q    <= 1'b0;
      ins_q      <= 32'h0000_0000;
      io_addr    <= 5'h00;
    end else begin
      case (st_q)
        st_idle: begin
          if (bus_fin && ph_wr_q && ph_adr_q == CIE_CMD_OFS) begin
            ins_q   <= hwdata;
            io_addr <= hwdata[CIE_D_LSB +: 5];
            st_q    <= st_exec;
          end
        end
        st_exec: begin
          last_cyc_q <= cyc;
          taken_q    <= take;
          cnt_q      <= cyc - 3'h2;
          st_q       <= (cyc == CYC_ONE) ? st_idle : st_wait;
        end
        st_wait: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h0) begin
            st_q <= st_idle;
          end
        end
        default: begin
          st_q <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q    <= CIE_PC_RST;
      flags_q <= CIE_FLAGS_RST;
    end else if (exec) begin
      pc_q <= pc_nx;
      if (wr_fl) begin
        flags_q <= alu_fl;
      end else if (op == handler_exit) begin
        flags_q[FLAG_I] <= 1'b1;
      end
    end else if (bus_fin && ph_wr_q && ph_adr_q == CIE_PC_OFS) begin
      pc_q <= hwdata[CIE_PC_W-1:0];
    end else if (bus_fin && ph_wr_q && ph_adr_q == CIE_FLAGS_OFS) begin
      flags_q <= hwdata[7:0];
    end
  end

  // The hardware stack is shallow; deeper nesting silently drops the oldest entry.
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stk
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stk_q[i] <= CIE_PC_RST;
      end else if (exec && push) begin
        stk_q[i] <= (i == 0) ? pc_q + 12'h001 : stk_q[(i == 0) ? 0 : i - 1];
      end else if (exec && pop && i < STACK_DEPTH - 1) begin
        stk_q[i] <= stk_q[(i < STACK_DEPTH - 1) ? i + 1 : i];
      end
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign stall   = ph_wr_q && (st_q != st_idle);
  assign bus_fin = ph_act_q && !stall;

  always_comb begin
    rdmux = 32'h0000_0000;
    if (ph_adr_q[7]) begin
      rdmux = {24'h000000, rd_c};
    end else begin
      case (ph_adr_q)
        CIE_CMD_OFS:   rdmux = ins_q;
        CIE_PC_OFS:    rdmux = {20'h00000, pc_q};
        CIE_FLAGS_OFS: rdmux = {24'h000000, flags_q};
        CIE_STAT_OFS:  rdmux = {27'h0000000, taken_q, last_cyc_q, st_q != st_idle};
        default:       rdmux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_act_q  <= 1'b0;
      ph_wr_q   <= 1'b0;
      ph_adr_q  <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hready && hsel && htrans[1]) begin
        ph_act_q  <= 1'b1;
        ph_wr_q   <= hwrite;
        ph_adr_q  <= {haddr[7:2], 2'b00};
        hreadyout <= 1'b0;
      end else if (bus_fin) begin
        ph_act_q  <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= ph_wr_q ? 32'h0000_0000 : rdmux;
      end
    end
  end

endmodule

// file: cie_core_props.sv
// Bus-side checker for the core execution block.
`timescale 1ns/10ps
module cie_core_props (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic        hreadyout,
  input logic [31:0] hrdata,
  input logic        hresp,
  input logic [4:0]  io_addr
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic req;
  logic rd;
  assign req = hsel && hready && htrans[1];
  assign rd  = req && !hwrite;
  // ****************************************
  // Transfer timing
  // ****************************************
  property p_take; req |=> !hreadyout; endproperty
  a_take: assert property (p_take) else $error("no wait state after address phase");
  property p_rd_one; rd |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_one: assert property (p_rd_one) else $error("read not done in one wait");
  // The longest instruction is four edges, so a stalled write ends well inside this bound.
  property p_wait; $fell(hreadyout) |-> ##[1:12] hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("wait state too long");
  property p_cause; !hreadyout |-> $past(req) || !$past(hreadyout); endproperty
  a_cause: assert property (p_cause) else $error("wait state without transfer");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  // ****************************************
  // Read data and I/O address
  // ****************************************
  property p_hold; !$stable(hrdata) |-> $rose(hreadyout); endproperty
  a_hold: assert property (p_hold) else $error("read data moved mid transfer");
  property p_unmap; rd && !haddr[7] && haddr[6:4] != 3'h0 |-> ##2 hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_stat; rd && haddr[7:2] == 6'h03 |-> ##2 hrdata[31:5] == 27'h0; endproperty
  a_stat: assert property (p_stat) else $error("status upper bits set");
  property p_rfw; rd && haddr[7] |-> ##2 hrdata[31:8] == 24'h0; endproperty
  a_rfw: assert property (p_rfw) else $error("register upper bits set");
  property p_io; !$stable(io_addr) |-> $rose(hreadyout); endproperty
  a_io: assert property (p_io) else $error("io address moved off command");
  c_rd: cover property (rd ##2 hreadyout);
  c_stall: cover property ($fell(hreadyout) ##1 !hreadyout);
  c_io: cover property (!$stable(io_addr));
endmodule
bind cie_core cie_core_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .io_addr(io_addr));

// file: cie_core_tb.sv
// Self-checking testbench for the core execution block.
`timescale 1ns/10ps
module cie_core_tb;
  import cie_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [4:0]  io_addr;
  logic [7:0]  io_rdata;
  logic [31:0] rd_q;
  logic [7:0]  f;
  int          n_fail;
  int          n_tests;
  localparam logic [31:0] M_ALL = 32'hffff_ffff;
  localparam logic [31:0] M_CYC = 32'h0000_000f;
  // Entry: op, destination, source or constant, result, flags (preset flags c1).
  localparam logic [39:0] ALU_TAB [18] = '{
    40'h00_12_34_12_c1, 40'h01_0f_01_10_e0, 40'h02_7f_00_80_ec, 40'h03_10_20_f0_d5,
    40'h04_80_01_7f_f8, 40'h05_05_05_ff_f5, 40'h06_01_00_00_c2, 40'h07_f0_8f_80_d5,
    40'h08_0f_f0_00_c3, 40'h09_01_80_81_d5, 40'h0a_00_00_00_c3, 40'h0b_aa_aa_00_c3,
    40'h0c_ff_0f_f0_d5, 40'h0d_90_90_90_d5, 40'h0e_20_20_20_c2, 40'h0f_00_00_00_f5,
    40'h10_40_41_40_f5, 40'h11_12_34_34_c1};
  // Entry: op, d, select, preset flags, expected status.
  localparam logic [39:0] SKP_TAB [14] = '{
    40'h16_01_02_00_14, 40'h16_01_03_00_02, 40'h17_01_01_00_14, 40'h18_01_01_00_02,
    40'h18_01_02_00_14, 40'h19_00_01_00_14, 40'h1a_00_01_00_02, 40'h1a_00_00_00_14,
    40'h19_05_00_00_14, 40'h1c_00_04_14_02, 40'h1b_00_04_14_14, 40'h1c_00_04_0c_14,
    40'h1b_00_00_01_14, 40'h1c_00_00_01_02};

  cie_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .io_addr(io_addr), .io_rdata(io_rdata));
  cie_io_model u_io (.io_addr(io_addr), .io_rdata(io_rdata));

  always #10 hclk = ~hclk;

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The slave may stall for several edges, so the wait is bounded, not fixed.
  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        chk({31'h0, hreadyout}, 32'h1);
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask

  task automatic ahb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd_q = hrdata;
  endtask

  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    ahb_xfer(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    ahb_xfer(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask

  function automatic logic [7:0] rf(input int n);
    return CIE_RF_BASE + 8'(n * 4);
  endfunction

  function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] d,
                                     input logic [4:0] r, input logic [7:0] k);
    return {2'h0, op, 3'h0, d, 3'h0, r, k};
  endfunction

  task automatic exec(input logic [31:0] c, input logic [31:0] st, input logic [31:0] m);
    int i;
    ahb_wr(CIE_CMD_OFS, c);
    i = 0;
    do begin
      ahb_xfer(1'b0, CIE_STAT_OFS, 32'h0);
      i++;
    end while (rd_q[0] !== 1'b0 && i < 20);
    chk(rd_q & m, st);
    chk({27'h0, io_addr}, {27'h0, c[20:16]});
  endtask

  task automatic skp(input logic [39:0] e);
    ahb_wr(CIE_FLAGS_OFS, {24'h0, e[15:8]});
    exec(mk(e[37:32], e[28:24], e[20:16], 8'h00), {24'h0, e[7:0]}, M_ALL);
    rchk(CIE_FLAGS_OFS, {24'h0, e[15:8]});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_fail = 0;
    n_tests = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(CIE_PC_OFS, 32'h0);
    rchk(CIE_FLAGS_OFS, 32'h0);
    ahb_wr(8'h40, 32'hdead_beef);
    rchk(8'h40, 32'h0);
    $display("Reset test done");
    for (int e = 0; e < 18; e++) begin
      ahb_wr(rf(1), {24'h0, ALU_TAB[e][31:24]});
      ahb_wr(rf(2), {24'h0, ALU_TAB[e][23:16]});
      ahb_wr(CIE_FLAGS_OFS, 32'hc1);
      exec(mk(ALU_TAB[e][37:32], 5'h1, 5'h2, ALU_TAB[e][23:16]), 32'h2, M_ALL);
      rchk(rf(1), {24'h0, ALU_TAB[e][15:8]});
      rchk(CIE_FLAGS_OFS, {24'h0, ALU_TAB[e][7:0]});
    end
    $display("Arithmetic test done");
    ahb_wr(rf(1), 32'h55);
    ahb_wr(rf(2), 32'h55);
    ahb_wr(rf(3), 32'h54);
    for (int e = 0; e < 14; e++) skp(SKP_TAB[e]);
    for (int s = 0; s < 8; s++) begin
      for (int p = 0; p < 2; p++) begin
        f = p ? 8'(1 << s) : ~8'(1 << s);
        skp({8'h1b, 8'h0, 3'h0, 5'(s), f, p ? 8'h14 : 8'h02});
        skp({8'h1c, 8'h0, 3'h0, 5'(s), f, p ? 8'h02 : 8'h14});
      end
    end
    ahb_wr(CIE_PC_OFS, 32'h020);
    exec(mk(6'h16, 5'h1, 5'h2, 8'h00), 32'h14, M_ALL);
    rchk(CIE_PC_OFS, 32'h022);
    $display("Skip and branch test done");
    ahb_wr(CIE_FLAGS_OFS, 32'h0);
    ahb_wr(CIE_PC_OFS, 32'h100);
    exec(mk(6'h12, 5'h0, 5'h00, 8'h05), 32'h4, M_CYC);
    rchk(CIE_PC_OFS, 32'h106);
    exec(mk(6'h12, 5'h0, 5'h0f, 8'hfe), 32'h4, M_CYC);
    rchk(CIE_PC_OFS, 32'h105);
    exec(mk(6'h13, 5'h0, 5'h00, 8'h10), 32'h6, M_CYC);
    rchk(CIE_PC_OFS, 32'h116);
    exec(mk(6'h14, 5'h0, 5'h00, 8'h00), 32'h8, M_CYC);
    rchk(CIE_PC_OFS, 32'h106);
    exec(mk(6'h13, 5'h0, 5'h00, 8'h00), 32'h6, M_CYC);
    exec(mk(6'h15, 5'h0, 5'h00, 8'h00), 32'h8, M_CYC);
    rchk(CIE_PC_OFS, 32'h107);
    rchk(CIE_FLAGS_OFS, 32'h80);
    // A write issued while the call still runs must wait, not be overwritten.
    ahb_wr(CIE_CMD_OFS, mk(6'h13, 5'h0, 5'h0, 8'h20));
    ahb_wr(CIE_PC_OFS, 32'h0aa);
    rchk(CIE_PC_OFS, 32'h0aa);
    rchk(CIE_CMD_OFS, mk(6'h13, 5'h0, 5'h0, 8'h20));
    $display("Program counter test done");
    ahb_wr(rf(30), 32'h05);
    ahb_wr(rf(5), 32'h77);
    ahb_wr(rf(7), 32'h3c);
    ahb_wr(CIE_FLAGS_OFS, 32'h2a);
    exec(mk(6'h1d, 5'h9, 5'h0, 8'h00), 32'h4, M_CYC);
    rchk(rf(9), 32'h77);
    exec(mk(6'h1e, 5'h0, 5'h7, 8'h00), 32'h4, M_CYC);
    rchk(rf(5), 32'h3c);
    rchk(CIE_FLAGS_OFS, 32'h2a);
    $display("Indirect access test done");
    print_verdict();
  end
endmodule

// file: cie_io_model.sv
// Behavioural model of the I/O register space seen by the core.
`timescale 1ns/10ps
module cie_io_model #(
  parameter logic [7:0] BASE = 8'ha5
) (
  input  logic [4:0] io_addr,
  output logic [7:0] io_rdata
);
  // Every location gives its own pattern, so a wrong address shows up as a wrong skip.
  assign io_rdata = BASE ^ {3'h0, io_addr};
endmodule

// file: cie_pkg.sv
// Constants, types and register map of the core execution block.
package cie_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CIE_CMD_OFS   = 8'h00;
  localparam logic [7:0] CIE_PC_OFS    = 8'h04;
  localparam logic [7:0] CIE_FLAGS_OFS = 8'h08;
  localparam logic [7:0] CIE_STAT_OFS  = 8'h0c;
  localparam logic [7:0] CIE_RF_BASE   = 8'h80;
  localparam logic [7:0] CIE_FLAGS_RST = 8'h00;
  localparam int         CIE_PC_W      = 12;
  localparam logic [CIE_PC_W-1:0] CIE_PC_RST = 12'h000;

  // ****************************************
  // Command word fields
  // ****************************************
  localparam int CIE_OP_LSB = 24;
  localparam int CIE_D_LSB  = 16;
  localparam int CIE_R_LSB  = 8;
  localparam logic [4:0] CIE_PTR_IDX = 5'h1e;

  // ****************************************
  // Flag positions
  // ****************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ****************************************
  // Cycle counts
  // ****************************************
  localparam logic [2:0] CYC_ONE  = 3'h1;
  localparam logic [2:0] CYC_JUMP = 3'h2;
  localparam logic [2:0] CYC_CALL = 3'h3;
  localparam logic [2:0] CYC_RET  = 3'h4;
  localparam logic [2:0] CYC_MEM  = 3'h2;
  localparam logic [2:0] CYC_TAKEN = 3'h2;

  typedef enum logic [5:0] {
    op_nop, op_add, op_add_carry, op_sub, op_sub_const, op_sub_carry,
    difference_const_with_carry, op_and, bitwise_conjunction_const, op_or, op_or_const,
    exclusive_disjunction, clear_reg_bits, zero_minus_check, op_compare,
    op_compare_carry, compare_immediate, reg_copy, relative_jump, relative_call,
    subroutine_exit, handler_exit, skip_if_equal, skip_reg_bit_low, skip_reg_bit_high,
    skip_io_bit_low, skip_io_bit_high, branch_flag_high, branch_flag_low,
    indirect_read, indirect_write
  } cie_op_t;

  typedef enum logic [2:0] {fn_add, fn_sub, fn_and, fn_or, fn_xor, fn_pass} cie_fn_t;

  typedef enum logic [1:0] {st_idle, st_exec, st_wait} cie_state_t;

endpackage

// file: cie_regfile.sv
// Working register file with two core read ports, one bus read port and pointer output.
`timescale 1ns/10ps
module cie_regfile
  import cie_pkg::*;
#(
  parameter int N = 32
) (
  input  logic       clk,
  input  logic       rst_n,
  input  logic       we,
  input  logic [4:0] waddr,
  input  logic [7:0] wdata,
  input  logic [4:0] ra_a,
  input  logic [4:0] ra_b,
  input  logic [4:0] ra_c,
  output logic [7:0] rd_a,
  output logic [7:0] rd_b,
  output logic [7:0] rd_c,
  output logic [7:0] ptr
);

  logic [7:0] mem_q [N];

  for (genvar i = 0; i < N; i++) begin : g_ent
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[i] <= 8'h00;
      end else if (we && (waddr == 5'(i))) begin
        mem_q[i] <= wdata;
      end
    end
  end

  assign rd_a = mem_q[ra_a];
  assign rd_b = mem_q[ra_b];
  assign rd_c = mem_q[ra_c];
  assign ptr  = mem_q[CIE_PTR_IDX];

endmodule
